/* File: verilog/crs_sequencer.sv */
// Reset, interrupt and background sequencer of the core
// Operation
// - Indexed long mode address is the index pair plus a 16-bit offset.
// - Stack short mode address is the stack pointer plus an unsigned 8-bit offset.
// - Stack long mode address is the stack pointer plus a 16-bit offset.
// - Power-on, watchdog timeout and a low reset pin are reset causes.
// - A reset cause aborts the operation in progress immediately.
// - Reset ends only when source check is done and the pin is released.
// - After reset six cycles fetch the vector from the top two bytes.
// - An interrupt waits for the end of the current instruction.
// - Interrupt vector follows the highest priority pending request at entry.
// - Entry pushes pc low, pc high, index low, accumulator then ccr.
// - After stacking the interrupt mask bit in ccr is set.
// - A debug command during stop restarts clocks into background mode.
// - The background instruction halts user code into background mode.
// - Background exits only by reset or resume, single step or tagged resume.
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer
  import crs_pkg::*;
(
  input wire logic i_clk, // Core clock 250 MHz
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire logic i_power_on_reset, // Power-on reset event
  input wire logic i_watchdog_timeout, // Operating watchdog timeout
  input wire logic i_reset_pin_n, // External reset pin, active low
  input wire logic i_source_check_done, // Reset source determination finished
  input wire crs_regs_type i_regs, // Core registers at instruction end
  input wire logic i_instr_end, // Current instruction completes
  input wire logic i_enter_background_instruction_exec, // Background instruction executed
  input wire logic i_stop_mode, // Core is in stop mode
  input wire logic i_dbg_cmd, // Debug command received
  input wire logic i_resume_cmd, // Resume command
  input wire logic i_step_cmd, // Single step command
  input wire logic i_tagged_cmd, // Tagged resume command
  input wire logic [7:0] i_irq, // Interrupt requests, bit 0 highest
  input wire crs_mode_type i_mode, // Operand addressing mode
  input wire logic [15:0] i_offset, // Instruction offset
  input wire logic [7:0] i_rdata, // Memory read data
  output crs_bus_type o_bus, // Memory access
  output logic [15:0] o_operand_addr, // Computed operand address
  output logic [15:0] o_pc, // Program counter
  output logic [7:0] o_ccr, // Condition code register
  output logic o_running, // Executing user code
  output logic o_background, // Active background mode
  output logic o_clk_enable, // Core clocks running
  output logic o_core_reset // Core held in reset
);
  typedef struct packed {
    crs_state_type st;
    logic [2:0] cnt;
    logic [15:0] pc;
    logic [7:0] condition_code_register;
    logic [15:0] vec;
    crs_regs_type ctx;
    crs_bus_type bus;
    logic [15:0] oaddr;
    logic clk_en;
    logic step;
    logic running;
    logic bkgd;
    logic core_rst;
  } crs_state_all_type;

  crs_state_all_type s_q, s_d;
  logic pin_n_s, done_s, por_s, wdog_s, cause;
  logic [15:0] calc_addr;

  crs_sync u_sync_pin (.i_clk(i_clk), .i_d(i_reset_pin_n), .o_q(pin_n_s));
  crs_sync u_sync_done (.i_clk(i_clk), .i_d(i_source_check_done), .o_q(done_s));
  crs_sync u_sync_por (.i_clk(i_clk), .i_d(i_power_on_reset), .o_q(por_s));
  crs_sync u_sync_wdog (.i_clk(i_clk), .i_d(i_watchdog_timeout), .o_q(wdog_s));

  crs_addr_calc u_addr (
    .i_mode(i_mode),
    .i_index_pair(i_regs.index_pair),
    .i_stack_ptr(i_regs.stack_ptr),
    .i_offset(i_offset),
    .o_addr(calc_addr)
  );

  // Lowest set bit wins: bit 0 has highest priority
  function automatic logic [15:0] irq_vector(input logic [7:0] req);
    logic [15:0] v;
    v = VEC_TABLE_TOP;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        v = VEC_TABLE_TOP - {11'h000, 4'(i + 1), 1'b0};
      end
    end
    return v;
  endfunction

  function automatic crs_bus_type bus_op(input logic [15:0] a, input logic [7:0] d,
                                         input logic w);
    crs_bus_type b;
    b.valid = 1'b1;
    b.addr = a;
    b.data = d;
    b.write = w;
    return b;
  endfunction

  assign cause = por_s | wdog_s | ~pin_n_s;

  always_comb begin
    s_d = s_q;
    s_d.bus = '0;
    s_d.oaddr = calc_addr;
    // Single step returns to background after one instruction
    if (s_q.st == ST_BKGD && i_step_cmd) begin
      s_d.step = 1'b1;
    end else if (s_q.st == ST_RUN && i_instr_end) begin
      s_d.step = 1'b0;
    end
    case (s_q.st)
      ST_RESET: begin
        s_d.clk_en = 1'b1;
        s_d.cnt = 3'h0;
        if (done_s && pin_n_s && !cause) begin
          s_d.st = ST_VECTOR;
        end
      end
      ST_VECTOR: begin
        s_d.cnt = s_q.cnt + 3'h1;
        // Read data returns one cycle after the request leaves the bus register
        if (s_q.cnt == 3'h0) begin
          s_d.bus = bus_op(RESET_VEC_ADDR, 8'h00, 1'b0);
        end else if (s_q.cnt == 3'h1) begin
          s_d.bus = bus_op(RESET_VEC_ADDR_LO, 8'h00, 1'b0);
        end else if (s_q.cnt == 3'h2) begin
          s_d.pc[15:8] = i_rdata;
        end else if (s_q.cnt == 3'h3) begin
          s_d.pc[7:0] = i_rdata;
        end
        if (s_q.cnt == RESET_FETCH_CYCLES - 3'h1) begin
          s_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_instr_end) begin
          s_d.pc = i_regs.pc;
          s_d.condition_code_register = i_regs.condition_code_register;
          if (i_enter_background_instruction_exec) begin
            s_d.st = ST_BKGD;
          end else if (s_q.step) begin
            s_d.st = ST_BKGD;
          end else if ((|i_irq) && !i_regs.condition_code_register[CCR_MASK_BIT]) begin
            s_d.ctx = i_regs;
            s_d.vec = irq_vector(i_irq);
            s_d.cnt = 3'h0;
            s_d.st = ST_STACK;
          end else if (i_stop_mode) begin
            s_d.clk_en = 1'b0;
            s_d.st = ST_STOP;
          end
        end
      end
      ST_STACK: begin
        s_d.cnt = s_q.cnt + 3'h1;
        s_d.ctx.stack_ptr = s_q.ctx.stack_ptr - 16'h0001;
        case (s_q.cnt)
          3'h0: s_d.bus = bus_op(s_q.ctx.stack_ptr, s_q.ctx.pc[7:0], 1'b1);
          3'h1: s_d.bus = bus_op(s_q.ctx.stack_ptr, s_q.ctx.pc[15:8], 1'b1);
          3'h2: s_d.bus = bus_op(s_q.ctx.stack_ptr, s_q.ctx.index_pair[7:0], 1'b1);
          3'h3: s_d.bus = bus_op(s_q.ctx.stack_ptr, s_q.ctx.accumulator, 1'b1);
          default: begin
            s_d.bus = bus_op(s_q.ctx.stack_ptr, s_q.ctx.condition_code_register, 1'b1);
            s_d.condition_code_register[CCR_MASK_BIT] = 1'b1;
            s_d.cnt = 3'h0;
            s_d.st = ST_IVEC;
          end
        endcase
      end
      ST_IVEC: begin
        s_d.cnt = s_q.cnt + 3'h1;
        if (s_q.cnt == 3'h0) begin
          s_d.bus = bus_op(s_q.vec, 8'h00, 1'b0);
        end else if (s_q.cnt == 3'h1) begin
          s_d.bus = bus_op(s_q.vec + 16'h0001, 8'h00, 1'b0);
        end else if (s_q.cnt == 3'h2) begin
          s_d.pc[15:8] = i_rdata;
        end else if (s_q.cnt == 3'h3) begin
          s_d.pc[7:0] = i_rdata;
        end
        if (s_q.cnt == RESET_FETCH_CYCLES - 3'h1) begin
          s_d.st = ST_RUN;
        end
      end
      ST_BKGD: begin
        if (i_resume_cmd || i_step_cmd || i_tagged_cmd) begin
          s_d.st = ST_RUN;
        end
      end
      ST_STOP: begin
        if (i_dbg_cmd) begin
          s_d.clk_en = 1'b1;
          s_d.st = ST_BKGD;
        end else if (!i_stop_mode) begin
          s_d.clk_en = 1'b1;
          s_d.st = ST_RUN;
        end
      end
      default: s_d.st = ST_RESET;
    endcase
    if (cause) begin
      s_d.st = ST_RESET;
      s_d.bus = '0;
      s_d.cnt = 3'h0;
    end
    // Status outputs are registered copies of the next state
    s_d.running = (s_d.st == ST_RUN);
    s_d.bkgd = (s_d.st == ST_BKGD);
    s_d.core_rst = (s_d.st == ST_RESET);
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_q <= '0;
      // Reset leaves the state at RESET, so the core reset flag starts set
      s_q.core_rst <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_bus = s_q.bus;
  assign o_operand_addr = s_q.oaddr;
  assign o_pc = s_q.pc;
  assign o_ccr = s_q.condition_code_register;
  assign o_running = s_q.running;
  assign o_background = s_q.bkgd;
  assign o_clk_enable = s_q.clk_en;
  assign o_core_reset = s_q.core_rst;

  property p_abort;
    @(posedge i_clk) disable iff (!i_reset_n) cause |=> (s_q.st == ST_RESET);
  endproperty
  a_abort: assert property (p_abort) else $error("reset did not abort");

  property p_vec_fetch;
    @(posedge i_clk) disable iff (!i_reset_n)
      (s_q.st == ST_RESET && s_d.st == ST_VECTOR) |=> ##1 (o_bus.addr == RESET_VEC_ADDR);
  endproperty
  a_vec_fetch: assert property (p_vec_fetch) else $error("reset vector not fetched");

  property p_six;
    @(posedge i_clk) disable iff (!i_reset_n || cause)
      (s_q.st == ST_RESET && s_d.st == ST_VECTOR) |=> (s_q.st == ST_VECTOR) [*6] ##1 o_running;
  endproperty
  a_six: assert property (p_six) else $error("vector sequence not six cycles");

  property p_release;
    @(posedge i_clk) disable iff (!i_reset_n)
      (s_q.st == ST_RESET && !pin_n_s) |=> (s_q.st == ST_RESET);
  endproperty
  a_release: assert property (p_release) else $error("left reset with pin low");

  property p_mask;
    @(posedge i_clk) disable iff (!i_reset_n)
      (s_q.st == ST_STACK && s_d.st == ST_IVEC) |=> o_ccr[CCR_MASK_BIT];
  endproperty
  a_mask: assert property (p_mask) else $error("mask not set");

  property p_push_order;
    @(posedge i_clk) disable iff (!i_reset_n || cause)
      (s_q.st == ST_RUN && s_d.st == ST_STACK) |=>
        ##1 (o_bus.write && o_bus.data == $past(i_regs.pc[7:0], 2));
  endproperty
  a_push_order: assert property (p_push_order) else $error("pc low not first");

  property p_enter_background_instruction;
    @(posedge i_clk) disable iff (!i_reset_n || cause)
      (o_running && i_instr_end && i_enter_background_instruction_exec) |=> o_background;
  endproperty
  a_enter_background_instruction: assert property (p_enter_background_instruction) else $error("no background entry");

  property p_stay_bkgd;
    @(posedge i_clk) disable iff (!i_reset_n || cause)
      (o_background && !i_resume_cmd && !i_step_cmd && !i_tagged_cmd) |=> o_background;
  endproperty
  a_stay_bkgd: assert property (p_stay_bkgd) else $error("left background");

  property p_stop_dbg;
    @(posedge i_clk) disable iff (!i_reset_n || cause)
      (s_q.st == ST_STOP && i_dbg_cmd) |=> (o_background && o_clk_enable);
  endproperty
  a_stop_dbg: assert property (p_stop_dbg) else $error("stop debug wake failed");

  property p_vec_lo;
    @(posedge i_clk) disable iff (!i_reset_n || cause)
      (s_q.st == ST_RESET && s_d.st == ST_VECTOR) |=> ##2 (o_bus.addr == RESET_VEC_ADDR_LO);
  endproperty
  a_vec_lo: assert property (p_vec_lo) else $error("reset vector low byte not fetched");

  property p_return_pc;
    @(posedge i_clk) disable iff (!i_reset_n || cause)
      (o_running && i_instr_end) |=> (o_pc == $past(i_regs.pc));
  endproperty
  a_return_pc: assert property (p_return_pc) else $error("return point not kept");

  property p_masked;
    @(posedge i_clk) disable iff (!i_reset_n || cause)
      (o_running && i_instr_end && i_regs.condition_code_register[CCR_MASK_BIT]) |=> (s_q.st != ST_STACK);
  endproperty
  a_masked: assert property (p_masked) else $error("masked request was taken");
endmodule
`default_nettype wire

/* File: verilog/crs_pkg.sv */
// Package of constants and types for the reset and interrupt sequencer
package crs_pkg;
  localparam logic [15:0] RESET_VEC_ADDR = 16'hFFFE;
  localparam logic [15:0] RESET_VEC_ADDR_LO = 16'hFFFF;
  localparam logic [2:0] RESET_FETCH_CYCLES = 3'h6;
  localparam logic [3:0] IRQ_SOURCES = 4'h8;
  localparam logic [15:0] VEC_TABLE_TOP = 16'hFFFC;
  localparam int CCR_MASK_BIT = 3;

  typedef enum logic [2:0] {
    MODE_NONE = 3'h0,
    MODE_INDEXED_LONG = 3'h1,
    MODE_STACK_SHORT = 3'h2,
    MODE_STACK_LONG = 3'h3
  } crs_mode_type;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_VECTOR = 3'h1,
    ST_RUN = 3'h2,
    ST_STACK = 3'h3,
    ST_IVEC = 3'h4,
    ST_BKGD = 3'h5,
    ST_STOP = 3'h6
  } crs_state_type;

  typedef struct packed {
    logic [15:0] index_pair;
    logic [15:0] stack_ptr;
    logic [7:0] accumulator;
    logic [7:0] condition_code_register;
    logic [15:0] pc;
  } crs_regs_type;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
    logic write;
  } crs_bus_type;
endpackage

/* File: verilog/crs_addr_calc.sv */
// Operand address generation for indexed and stack relative modes
`timescale 1ns/1ps
`default_nettype none
module crs_addr_calc
  import crs_pkg::*;
(
  input wire crs_mode_type i_mode, // Addressing mode
  input wire logic [15:0] i_index_pair, // Index pair value
  input wire logic [15:0] i_stack_ptr, // Stack pointer
  input wire logic [15:0] i_offset, // Instruction offset
  output logic [15:0] o_addr // Operand address
);
  always_comb begin
    case (i_mode)
      MODE_INDEXED_LONG: o_addr = i_index_pair + i_offset;
      MODE_STACK_SHORT: o_addr = i_stack_ptr + {8'h00, i_offset[7:0]};
      MODE_STACK_LONG: o_addr = i_stack_ptr + i_offset;
      default: o_addr = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

/* File: verilog/crs_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module crs_sync (
  input wire logic i_clk, // Core clock
  input wire logic i_d, // Asynchronous input
  output logic o_q // Synchronised level
);
  logic meta_q;
  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    o_q <= meta_q;
  end
endmodule
`default_nettype wire

/* File: bench/crs_host_model.sv */
// Host debug system and program memory model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module crs_host_model
  import crs_pkg::*;
(
  input wire logic i_clk, // Core clock
  input wire logic [2:0] i_cmd, // 1 debug, 2 resume, 3 step, 4 tagged
  input wire crs_bus_type i_bus, // Core memory access
  output logic o_dbg_cmd, // Debug command pulse
  output logic o_resume_cmd, // Resume pulse
  output logic o_step_cmd, // Single step pulse
  output logic o_tagged_cmd, // Tagged resume pulse
  output logic [7:0] o_rdata // Memory read data
);
  always @(posedge i_clk) begin
    o_dbg_cmd <= (i_cmd == 3'h1);
    o_resume_cmd <= (i_cmd == 3'h2);
    o_step_cmd <= (i_cmd == 3'h3);
    o_tagged_cmd <= (i_cmd == 3'h4);
    // Idle data toggles so a late sample never passes for a read
    if (i_bus.valid && !i_bus.write) begin
      o_rdata <= i_bus.addr[7:0] ^ 8'hA5;
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: bench/crs_sequencer_tb.sv */
// Self-checking bench for the reset and interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_tb;
  import crs_pkg::*;
  typedef struct packed {
    crs_mode_type mode;
    logic [15:0] idx, sp, off, exp;
  } crs_row_type;
  logic clk = 1'b0, rst_n = 1'b0, por = 1'b0, wdt = 1'b0, pin_n = 1'b0, done = 1'b0;
  logic iend = 1'b0, enter_background_instruction = 1'b0, stopm = 1'b0;
  logic [7:0] irq = 8'h00;
  logic [2:0] cmd = 3'h0;
  logic [15:0] off = 16'h0000;
  crs_mode_type mode = MODE_NONE;
  crs_regs_type regs = '0;
  crs_bus_type bus;
  logic [15:0] oaddr, pc;
  logic [7:0] condition_code_register, rdata;
  logic run, bg, clken, creset, dbg, res, stp, tag;
  int fails = 0;
  int samples_checked = 0;
  int n;
  logic [15:0] wa[$], rq[$];
  logic [7:0] wd[$];
  logic [7:0] st[5];
  crs_row_type rows[4];

  always #2 clk = ~clk;

  crs_sequencer uut (.i_clk(clk), .i_reset_n(rst_n), .i_power_on_reset(por),
    .i_watchdog_timeout(wdt), .i_reset_pin_n(pin_n), .i_source_check_done(done),
    .i_regs(regs), .i_instr_end(iend), .i_enter_background_instruction_exec(enter_background_instruction), .i_stop_mode(stopm),
    .i_dbg_cmd(dbg), .i_resume_cmd(res), .i_step_cmd(stp), .i_tagged_cmd(tag),
    .i_irq(irq), .i_mode(mode), .i_offset(off), .i_rdata(rdata), .o_bus(bus),
    .o_operand_addr(oaddr), .o_pc(pc), .o_ccr(condition_code_register), .o_running(run),
    .o_background(bg), .o_clk_enable(clken), .o_core_reset(creset));
  crs_host_model host (.i_clk(clk), .i_cmd(cmd), .i_bus(bus), .o_dbg_cmd(dbg),
    .o_resume_cmd(res), .o_step_cmd(stp), .o_tagged_cmd(tag), .o_rdata(rdata));

  always @(posedge clk) begin
    if (bus.valid && bus.write) begin
      wa.push_back(bus.addr);
      wd.push_back(bus.data);
    end else if (bus.valid) begin
      rq.push_back(bus.addr);
    end
  end

  function automatic logic [15:0] vec(input logic [15:0] a);
    return {a[7:0] ^ 8'hA5, (a[7:0] + 8'h01) ^ 8'hA5};
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic step_instr(input logic b);
    @(posedge clk);
    iend <= 1'b1;
    enter_background_instruction <= b;
    @(posedge clk);
    iend <= 1'b0;
    enter_background_instruction <= 1'b0;
    #1;
  endtask
  task automatic host_cmd(input logic [2:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 3'h0;
    #1;
  endtask
  task automatic wait_run;
    n = 0;
    while (run !== 1'b1 && n < 40) begin
      n++;
      tick(1);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole sequence takes well under a thousand cycles
  initial begin
    #20000;
    fails++;
    give_verdict();
  end

  initial begin
    rows = '{'{MODE_INDEXED_LONG, 16'h1234, 16'h0000, 16'hF000, 16'h0234},
      '{MODE_STACK_SHORT, 16'h0000, 16'h00F0, 16'h55FF, 16'h01EF},
      '{MODE_STACK_LONG, 16'h0000, 16'h8000, 16'h8001, 16'h0001},
      '{MODE_NONE, 16'h1111, 16'h2222, 16'h3333, 16'h0000}};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    pin_n <= 1'b1;
    tick(10);
    chk("core_reset", 16'h0001, 16'(creset));
    @(posedge clk);
    done <= 1'b1;
    pin_n <= 1'b0;
    tick(10);
    chk("core_reset", 16'h0001, 16'(creset));
    @(posedge clk);
    pin_n <= 1'b1;
    n = 0;
    while (creset !== 1'b0 && n < 20) begin
      n++;
      tick(1);
    end
    wait_run();
    chk("vector_cycles", 16'(RESET_FETCH_CYCLES), n[15:0]);
    chk("vec_hi_addr", RESET_VEC_ADDR, rq[0]);
    chk("vec_lo_addr", RESET_VEC_ADDR_LO, rq[1]);
    chk("reset_pc", vec(RESET_VEC_ADDR), pc);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk);
      regs <= '{rows[i].idx, rows[i].sp, 8'h00, 8'h00, 16'h0000};
      step_instr(1'b0);
      @(posedge clk);
      mode <= rows[i].mode;
      off <= rows[i].off;
      tick(3);
      chk("operand_addr", rows[i].exp, oaddr);
    end
    $display("test address table done");
    rq.delete();
    wa.delete();
    wd.delete();
    @(posedge clk);
    regs <= '{16'hABCD, 16'h01FF, 8'h3C, 8'h68, 16'h4321};
    irq <= 8'h28;
    tick(6);
    step_instr(1'b0);
    tick(8);
    chk("masked_writes", 16'h0000, 16'(wa.size()));
    @(posedge clk);
    regs.condition_code_register <= 8'h60;
    step_instr(1'b0);
    tick(3);
    wait_run();
    st = '{regs.pc[7:0], regs.pc[15:8], regs.index_pair[7:0], regs.accumulator, 8'h60};
    chk("stack_count", 16'h0005, 16'(wa.size()));
    for (int k = 0; k < 5; k++) begin
      chk("stack_addr", regs.stack_ptr - 16'(k), wa[k]);
      chk("stack_data", {8'h00, st[k]}, {8'h00, wd[k]});
    end
    chk("irq_vec_addr", VEC_TABLE_TOP - 16'h0008, rq[0]);
    chk("handler_pc", vec(VEC_TABLE_TOP - 16'h0008), pc);
    chk("ccr", 16'h0068, {8'h00, condition_code_register});
    @(posedge clk);
    irq <= 8'h00;
    $display("test interrupt done");
    // A breakpoint is the background opcode reached by execution
    step_instr(1'b1);
    tick(10);
    chk("background", 16'h0001, 16'(bg));
    chk("running", 16'h0000, 16'(run));
    for (int k = 2; k <= 4; k++) begin
      host_cmd(k[2:0]);
      tick(3);
      chk("resumed", 16'h0001, 16'(run));
      step_instr(k != 3);
      tick(3);
      chk("background", 16'h0001, 16'(bg));
    end
    $display("test background done");
    host_cmd(3'h2);
    @(posedge clk);
    stopm <= 1'b1;
    step_instr(1'b0);
    tick(3);
    chk("clk_enable", 16'h0000, 16'(clken));
    host_cmd(3'h1);
    tick(3);
    chk("background", 16'h0001, 16'(bg));
    chk("clk_enable", 16'h0001, 16'(clken));
    @(posedge clk);
    stopm <= 1'b0;
    host_cmd(3'h2);
    tick(3);
    chk("resumed", 16'h0001, 16'(run));
    $display("test stop wake done");
    for (int c = 0; c < 3; c++) begin
      wa.delete();
      @(posedge clk);
      irq <= 8'h01;
      iend <= 1'b1;
      por <= (c == 0);
      wdt <= (c == 1);
      pin_n <= (c != 2);
      @(posedge clk);
      iend <= 1'b0;
      tick(5);
      chk("core_reset", 16'h0001, 16'(creset));
      chk("aborted_stack", 16'h0000, 16'(wa.size() >= 5));
      @(posedge clk);
      {por, wdt, pin_n, irq} <= {2'h0, 1'b1, 8'h00};
      tick(1);
      wait_run();
      chk("reset_pc", vec(RESET_VEC_ADDR), pc);
    end
    $display("test reset causes done");
    give_verdict();
  end
endmodule
`default_nettype wire
